// ---- rtl/ampf_pkg.sv ----
// Constants, register map and carrier types of the amplifier audio path block
// What this block does
// - DC-blocking filter first, always on in pin mode
// - Register dc_block_bypass_ctrl bit 7 bypasses filter
// - DC at outputs disables stage, latches
// - Boost after filter, +6dB in pin mode
// - Volume mute to +24dB, register digital_volume_level
// - Volume code is 0xCF plus dB/0.5
// - Ramp 0.5dB per eight frame periods
// - Ramp config bit 7 disables ramping
// - Clipper limits to 20-bit level
// - Two complementary PWM pairs, one per channel
// - PWM rate integer multiple of frame rate
// - Six error kinds in status; four also on pin
// - Shutdown toggle clears; persisting error re-faults
// - Latched recovery needs toggle plus timeout
// - Non-latching errors recover automatically
// - Fault output open-drain, active low
// - Fault held low until playback resumes
// - Clock error pulls fault, recovers immediately
// - Supply errors non-latching, no fault pin
// - Clock error on bad ratio, rate, stop
// - Overcurrent and DC errors latch
// - Overtemp clear also needs hysteresis cool
// - DC when duty over 60% 420ms
package ampf_pkg;

	// Register offsets
	localparam logic [7:0] REG_PWR = 8'h01;
	localparam logic [7:0] REG_DCB = 8'h02;
	localparam logic [7:0] REG_RAMP = 8'h03;
	localparam logic [7:0] REG_VOL = 8'h04;
	localparam logic [7:0] REG_CLIP2 = 8'h05;
	localparam logic [7:0] REG_CLIP1 = 8'h06;
	localparam logic [7:0] REG_CLIP0 = 8'h07;
	localparam logic [7:0] REG_STAT = 8'h08;

	// Field positions
	localparam int PWR_RUN_BIT = 0;
	localparam int PWR_RATE_LSB = 2;
	localparam int DCB_BYPASS_BIT = 7;
	localparam int RAMP_OFF_BIT = 7;
	localparam int ST_OC = 0;
	localparam int ST_DC = 1;
	localparam int ST_OT = 2;
	localparam int ST_UV = 3;
	localparam int ST_OV = 4;
	localparam int ST_CLK = 5;
	localparam int ST_OVF = 6;

	// Reset values and fixed pin-mode settings
	localparam logic [7:0] PWR_RST = 8'h01;
	localparam logic [7:0] DCB_RST = 8'h01;
	localparam logic [7:0] RAMP_RST = 8'h00;
	localparam logic [7:0] VOL_0DB = 8'hCF;
	localparam logic [19:0] CLIP_RST = 20'hFFFFF;
	localparam logic [1:0] HW_BOOST = 2'h1;

	// Datapath constants
	localparam int I2S_WORD = 24;
	localparam int HPF_SHIFT = 10;
	localparam int PWM_BASE_SHIFT = 3;
	localparam int RAMP_FRAMES = 8;
	localparam int GAIN_BIAS = 9;
	localparam int GAIN_STEPS = 12;
	localparam int GAIN_NORM = 33;
	localparam logic [23:0] DC_LIMIT = 24'h19999A;
	localparam logic [15:0] VOL_FRAC [12] = '{16'h8000, 16'h879C, 16'h8FAD,
		16'h9838, 16'hA145, 16'hAADC, 16'hB505, 16'hBFC9, 16'hCB30,
		16'hD745, 16'hE412, 16'hF1A2};
	localparam logic [7:0] SCLK_RATIO [3] = '{8'h20, 8'h30, 8'h40};
	localparam logic [9:0] MCLK_RATIO [5] = '{10'h080, 10'h0C0, 10'h100,
		10'h180, 10'h200};

	// Timing
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned DC_TIME_MS = 420;
	localparam int unsigned DC_CYC = DC_TIME_MS * (CLK_HZ / 1000);
	localparam int unsigned CLK_STOP_US = 50;
	localparam int unsigned CLK_STOP_CYC = CLK_STOP_US * (CLK_HZ / 1_000_000);
	localparam int unsigned FAULT_TIMEOUT_MS = 100;
	localparam int unsigned FAULT_TIMEOUT_CYC =
		FAULT_TIMEOUT_MS * (CLK_HZ / 1000);
	localparam int unsigned FS_MIN_HZ = 12000;
	localparam int unsigned FS_MAX_HZ = 96000;
	localparam logic [15:0] FRAME_MAX_CYC = 16'(CLK_HZ / FS_MIN_HZ);
	// About 3% slack: a sampled frame jitters by a cycle and crystals
	// drift, so an exact bound would reject a genuine top-rate source
	localparam logic [15:0] FRAME_MIN_CYC =
		16'((CLK_HZ / FS_MAX_HZ) * 31 / 32);

	// Pins that arrive from outside the clock domain
	typedef struct packed {
		logic sclk;
		logic lrck;
		logic sdin;
		logic mclk;
		logic sd_n;
		logic oc;
		logic uv;
		logic ov;
		logic ot;
		logic ot_cool;
		logic sw_mode;
		logic [1:0] rate;
	} ampf_pin_t;

	// One stereo frame, index 0 left, 1 right
	typedef struct packed {
		logic [1:0][23:0] ch;
	} ampf_pair_t;

	typedef enum logic [1:0] {
		FLT_RUN,
		FLT_HOLD,
		FLT_ARMED,
		FLT_WAIT
	} ampf_flt_t;

endpackage : ampf_pkg

// ---- rtl/ampf_core.sv ----
// Audio path, PWM converter and protection manager of the amplifier
`timescale 1ns/100ps
module ampf_core #(
	parameter int unsigned DC_CYC = ampf_pkg::DC_CYC,
	parameter int unsigned CLK_STOP_CYC = ampf_pkg::CLK_STOP_CYC,
	parameter int unsigned FAULT_TIMEOUT_CYC = ampf_pkg::FAULT_TIMEOUT_CYC
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic aud_sclk,
	input wire logic aud_lrck,
	input wire logic aud_sdin,
	input wire logic aud_mclk,
	input wire logic amp_shutdown_n,
	input wire logic oc_detect,
	input wire logic uv_detect,
	input wire logic ov_detect,
	input wire logic ot_detect,
	input wire logic ot_cool,
	input wire logic sw_ctrl_mode,
	input wire logic [1:0] pwm_rate_pin,
	input wire logic reg_wr_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic [1:0] pwm_p,
	output logic [1:0] pwm_n,
	output logic power_stage_en,
	output logic amp_fault_out_n_o,
	output logic amp_fault_out_n_oe_n
);

	typedef struct packed {
		ampf_pkg::ampf_pin_t s1;
		ampf_pkg::ampf_pin_t s2;
		ampf_pkg::ampf_pin_t s3;
		logic [7:0] pwr;
		logic [7:0] dcb;
		logic [7:0] ramp;
		logic [7:0] vol;
		logic [19:0] clip;
		logic [23:0] sh;
		logic [5:0] bcnt;
		logic lr_at;
		logic [23:0] word_l;
		ampf_pkg::ampf_pair_t [1:0] fifo;
		logic wp;
		logic rp;
		logic [1:0] cnt;
		logic [1:0][23:0] xp;
		logic [1:0][23:0] yp;
		logic [1:0][23:0] smp;
		logic [7:0] vapp;
		logic [2:0] rcnt;
		logic [15:0] fcyc;
		logic [15:0] fper;
		logic [7:0] scnt;
		logic [9:0] mcnt;
		logic [31:0] sidle;
		logic [31:0] midle;
		logic [31:0] lidle;
		logic rbad;
		logic clk_err;
		logic [15:0] pcnt;
		logic [1:0][31:0] dcnt;
		logic [1:0] dsgn;
		logic dc_err;
		ampf_pkg::ampf_flt_t flt;
		logic [31:0] tcnt;
		logic [7:0] stat;
		logic [7:0] rdata;
		logic [1:0] pp;
		logic [1:0] pn;
		logic pen;
		logic fo;
		logic foe_n;
	} ampf_state_t;

	ampf_state_t st_q;
	ampf_state_t st_d;
	ampf_pkg::ampf_pin_t pins;

	// Saturate a wide signed value to 24 bits
	function automatic logic [23:0] ampf_sat24(input logic signed [63:0] v);
		if (v > 64'sh7FFFFF)
			return 24'h7FFFFF;
		if (v < -64'sh800000)
			return 24'h800000;
		return v[23:0];
	endfunction : ampf_sat24

	// Gain in half-dB steps: mantissa table times a power of two
	function automatic logic [23:0] ampf_gain(input logic [23:0] x,
		input logic [7:0] code);
		logic [8:0] m;
		logic [4:0] e;
		logic [3:0] f;
		logic signed [63:0] p;
		m = {1'b0, code} + 9'(ampf_pkg::GAIN_BIAS);
		e = 5'(m / 9'(ampf_pkg::GAIN_STEPS));
		f = 4'(m % 9'(ampf_pkg::GAIN_STEPS));
		p = 64'($signed(x)) * 64'($signed({1'b0, ampf_pkg::VOL_FRAC[f]}));
		p = (p <<< e) >>> ampf_pkg::GAIN_NORM;
		// Code zero is full mute
		if (code == 8'h00)
			return 24'h000000;
		return ampf_sat24(p);
	endfunction : ampf_gain

	assign pins = {aud_sclk, aud_lrck, aud_sdin, aud_mclk, amp_shutdown_n,
		oc_detect, uv_detect, ov_detect, ot_detect, ot_cool, sw_ctrl_mode,
		pwm_rate_pin};

	logic sw;
	logic sclk_r;
	logic lrck_r;
	logic lrck_e;
	logic mclk_r;
	logic sd_ok;
	logic bypass;
	logic ramp_off;
	logic push;
	logic pop;
	logic wrap;
	logic lat;
	logic ot_c;
	logic s_ok;
	logic m_ok;
	logic hi;
	logic [1:0] boost;
	logic [1:0] rate;
	logic [7:0] vol_t;
	logic [19:0] clip;
	logic [5:0] bn;
	logic [4:0] sa;
	logic [23:0] word;
	logic [23:0] x;
	logic [23:0] y;
	logic [23:0] v;
	logic [23:0] lvl;
	logic [15:0] per;
	logic [23:0] prod;
	logic signed [63:0] t;
	ampf_pkg::ampf_pair_t pair;

	// Whole next-state function
	always_comb begin
		st_d = st_q;
		sw = st_q.s2.sw_mode;
		sclk_r = st_q.s2.sclk & ~st_q.s3.sclk;
		lrck_r = st_q.s2.lrck & ~st_q.s3.lrck;
		lrck_e = st_q.s2.lrck ^ st_q.s3.lrck;
		mclk_r = st_q.s2.mclk & ~st_q.s3.mclk;
		sd_ok = st_q.s2.sd_n & (~sw | st_q.pwr[ampf_pkg::PWR_RUN_BIT]);
		push = 1'b0;
		pop = 1'b0;
		wrap = 1'b0;
		s_ok = 1'b0;
		m_ok = 1'b0;
		hi = 1'b0;
		bn = 6'h00;
		sa = 5'h00;
		word = 24'h000000;
		x = 24'h000000;
		y = 24'h000000;
		v = 24'h000000;
		prod = 24'h000000;
		t = 64'sh0;
		pair = st_q.fifo[st_q.rp];

		// Two-stage pin synchronisers; s3 only feeds edge detection
		st_d.s1 = pins;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;

		bypass = sw & st_q.dcb[ampf_pkg::DCB_BYPASS_BIT];
		boost = sw ? st_q.dcb[1:0] : ampf_pkg::HW_BOOST;
		vol_t = sw ? st_q.vol : ampf_pkg::VOL_0DB;
		ramp_off = sw & st_q.ramp[ampf_pkg::RAMP_OFF_BIT];
		clip = sw ? st_q.clip : ampf_pkg::CLIP_RST;
		rate = sw ? st_q.pwr[ampf_pkg::PWR_RATE_LSB +: 2] : st_q.s2.rate;
		lvl = {1'b0, clip, 3'h7};

		// Control port writes
		if (reg_wr_en) begin
			case (reg_addr)
				ampf_pkg::REG_PWR: st_d.pwr = reg_wdata;
				ampf_pkg::REG_DCB: st_d.dcb = reg_wdata;
				ampf_pkg::REG_RAMP: st_d.ramp = reg_wdata;
				ampf_pkg::REG_VOL: st_d.vol = reg_wdata;
				ampf_pkg::REG_CLIP2: st_d.clip[19:16] = reg_wdata[3:0];
				ampf_pkg::REG_CLIP1: st_d.clip[15:8] = reg_wdata;
				ampf_pkg::REG_CLIP0: st_d.clip[7:0] = reg_wdata;
				ampf_pkg::REG_STAT: begin
					if (reg_wdata[ampf_pkg::ST_OVF])
						st_d.stat[ampf_pkg::ST_OVF] = 1'b0;
				end
				default: ;
			endcase
		end

		// Serial receiver: first 24 bits of each half-frame, MSB first
		if (sclk_r) begin
			bn = (st_q.bcnt == 6'h3F) ? st_q.bcnt : st_q.bcnt + 6'h01;
			if (st_q.bcnt < 6'(ampf_pkg::I2S_WORD))
				st_d.sh = {st_q.sh[22:0], st_q.s2.sdin};
			st_d.bcnt = bn;
			st_d.lr_at = st_q.s2.lrck;
			// Side change: bit just taken still closed the old word
			if (st_q.s2.lrck != st_q.lr_at) begin
				sa = (bn >= 6'(ampf_pkg::I2S_WORD)) ? 5'h00 :
					5'(6'(ampf_pkg::I2S_WORD) - bn);
				word = st_d.sh << sa;
				if (!st_q.lr_at)
					st_d.word_l = word;
				else
					push = 1'b1;
				st_d.sh = 24'h000000;
				st_d.bcnt = 6'h00;
			end
		end

		// Two-entry buffer; a full buffer drops the frame and flags it
		if (push) begin
			if (st_q.cnt != 2'h2) begin
				st_d.fifo[st_q.wp].ch[0] = st_q.word_l;
				st_d.fifo[st_q.wp].ch[1] = word;
				st_d.wp = ~st_q.wp;
			end else begin
				st_d.stat[ampf_pkg::ST_OVF] = 1'b1;
			end
		end

		if (lrck_r) begin
			for (int i = 0; i < 3; i++)
				s_ok = s_ok | (st_q.scnt == ampf_pkg::SCLK_RATIO[i]);
			for (int i = 0; i < 5; i++)
				m_ok = m_ok | (st_q.mcnt == ampf_pkg::MCLK_RATIO[i]);
			st_d.rbad = ~s_ok | ~m_ok |
				(st_q.fcyc < ampf_pkg::FRAME_MIN_CYC) |
				(st_q.fcyc > ampf_pkg::FRAME_MAX_CYC);
			st_d.fper = st_q.fcyc;
			st_d.fcyc = 16'h0001;
			st_d.scnt = {7'h00, sclk_r};
			st_d.mcnt = {9'h000, mclk_r};
		end else begin
			if (st_q.fcyc != 16'hFFFF)
				st_d.fcyc = st_q.fcyc + 16'h0001;
			if (sclk_r && st_q.scnt != 8'hFF)
				st_d.scnt = st_q.scnt + 8'h01;
			if (mclk_r && st_q.mcnt != 10'h3FF)
				st_d.mcnt = st_q.mcnt + 10'h001;
		end

		st_d.sidle = sclk_r ? 32'h0 :
			(st_q.sidle < CLK_STOP_CYC) ? st_q.sidle + 32'h1 : st_q.sidle;
		st_d.midle = mclk_r ? 32'h0 :
			(st_q.midle < CLK_STOP_CYC) ? st_q.midle + 32'h1 : st_q.midle;
		st_d.lidle = lrck_e ? 32'h0 :
			(st_q.lidle < CLK_STOP_CYC) ? st_q.lidle + 32'h1 : st_q.lidle;
		st_d.clk_err = st_q.rbad | (st_q.sidle >= CLK_STOP_CYC) |
			(st_q.midle >= CLK_STOP_CYC) | (st_q.lidle >= CLK_STOP_CYC);
		// A stop voids the last rate check; return waits for a fresh
		// frame instead of releasing on a stale one and re-faulting
		if ((st_q.sidle >= CLK_STOP_CYC) | (st_q.midle >= CLK_STOP_CYC) |
			(st_q.lidle >= CLK_STOP_CYC))
			st_d.rbad = 1'b1;

		// ramp off applies target at once
		if (ramp_off) begin
			st_d.vapp = vol_t;
			st_d.rcnt = 3'h0;
		end else if (lrck_r) begin
			st_d.rcnt = st_q.rcnt + 3'h1;
			// one half-dB step per 8 frames
			if (st_q.rcnt == 3'(ampf_pkg::RAMP_FRAMES - 1)) begin
				if (st_q.vapp < vol_t)
					st_d.vapp = st_q.vapp + 8'h01;
				else if (st_q.vapp > vol_t)
					st_d.vapp = st_q.vapp - 8'h01;
			end
		end

		// Carrier period is the frame period over 8, 16, 32 or 64
		per = st_q.fper >> (ampf_pkg::PWM_BASE_SHIFT + 32'(rate));
		if (per == 16'h0000)
			per = 16'h0001;
		wrap = st_q.pcnt >= per - 16'h0001;
		st_d.pcnt = wrap ? 16'h0000 : st_q.pcnt + 16'h0001;
		// Drain stalls while the stage is off so the buffer really fills
		pop = wrap & (st_q.cnt != 2'h0) & st_q.pen;
		if (pop)
			st_d.rp = ~st_q.rp;
		st_d.cnt = st_q.cnt + {1'b0, push & (st_q.cnt != 2'h2)} -
			{1'b0, pop};

		for (int c = 0; c < 2; c++) begin
			if (pop) begin
				x = pair.ch[c];
				t = 64'($signed(x)) - 64'($signed(st_q.xp[c])) +
					64'($signed(st_q.yp[c])) -
					(64'($signed(st_q.yp[c])) >>> ampf_pkg::HPF_SHIFT);
				y = ampf_sat24(t);
				st_d.xp[c] = x;
				st_d.yp[c] = y;
				if (bypass)
					y = x;
				y = ampf_sat24(64'($signed(y)) <<< boost);
				v = ampf_gain(y, st_q.vapp);
				if ($signed(v) > $signed(lvl))
					v = lvl;
				else if ($signed(v) < -$signed(lvl))
					v = -lvl;
				st_d.smp[c] = v;
			end

			// complementary pair, both low when off
			prod = {16'h0000, ~st_q.smp[c][23], st_q.smp[c][22:16]} *
				{8'h00, per};
			st_d.pp[c] = st_q.pen & (st_q.pcnt < prod[23:8]);
			st_d.pn[c] = st_q.pen & ~(st_q.pcnt < prod[23:8]);

			hi = ($signed(st_q.smp[c]) > $signed(ampf_pkg::DC_LIMIT)) |
				($signed(st_q.smp[c]) < -$signed(ampf_pkg::DC_LIMIT));
			st_d.dsgn[c] = st_q.smp[c][23];
			if (!st_q.pen || !hi || st_q.smp[c][23] != st_q.dsgn[c])
				st_d.dcnt[c] = 32'h0;
			else if (st_q.dcnt[c] < DC_CYC)
				st_d.dcnt[c] = st_q.dcnt[c] + 32'h1;
			if (st_q.dcnt[c] >= DC_CYC)
				st_d.dc_err = 1'b1;
		end
		// Detector restarts across shutdown so release re-checks it
		if (!sd_ok)
			st_d.dc_err = 1'b0;

		// overtemp holds until cooled below hysteresis
		ot_c = st_q.s2.ot | (st_q.stat[ampf_pkg::ST_OT] & ~st_q.s2.ot_cool);
		lat = st_q.s2.oc | st_q.dc_err | ot_c;
		if (lat)
			st_d.stat[2:0] = st_q.stat[2:0] |
				{ot_c, st_q.dc_err, st_q.s2.oc};
		// supply errors are live status only
		st_d.stat[ampf_pkg::ST_UV] = st_q.s2.uv;
		st_d.stat[ampf_pkg::ST_OV] = st_q.s2.ov;
		st_d.stat[ampf_pkg::ST_CLK] = st_q.clk_err;

		case (st_q.flt)
			ampf_pkg::FLT_RUN: begin
				if (lat)
					st_d.flt = ampf_pkg::FLT_HOLD;
			end
			ampf_pkg::FLT_HOLD: begin
				if (!sd_ok)
					st_d.flt = ampf_pkg::FLT_ARMED;
			end
			ampf_pkg::FLT_ARMED: begin
				if (sd_ok) begin
					st_d.tcnt = 32'h0;
					st_d.flt = lat ? ampf_pkg::FLT_HOLD : ampf_pkg::FLT_WAIT;
				end
			end
			ampf_pkg::FLT_WAIT: begin
				if (!sd_ok)
					st_d.flt = ampf_pkg::FLT_ARMED;
				else if (lat)
					st_d.flt = ampf_pkg::FLT_HOLD;
				else if (st_q.tcnt >= FAULT_TIMEOUT_CYC - 1) begin
					st_d.flt = ampf_pkg::FLT_RUN;
					st_d.stat[2:0] = 3'h0;
				end else
					st_d.tcnt = st_q.tcnt + 32'h1;
			end
			default: st_d.flt = ampf_pkg::FLT_RUN;
		endcase

		// non-latching errors gate playback only while present
		st_d.pen = sd_ok & (st_q.flt == ampf_pkg::FLT_RUN) & ~lat &
			~st_q.clk_err & ~st_q.s2.uv & ~st_q.s2.ov;
		// open drain, only ever pulls low
		st_d.fo = 1'b0;
		// held low through the latched recovery
		// clock error pulls low without timeout
		st_d.foe_n = ~((st_q.flt != ampf_pkg::FLT_RUN) | st_q.clk_err);

		// Read data follows the address one cycle later
		case (reg_addr)
			ampf_pkg::REG_PWR: st_d.rdata = st_q.pwr;
			ampf_pkg::REG_DCB: st_d.rdata = st_q.dcb;
			ampf_pkg::REG_RAMP: st_d.rdata = st_q.ramp;
			ampf_pkg::REG_VOL: st_d.rdata = st_q.vol;
			ampf_pkg::REG_CLIP2: st_d.rdata = {4'h0, st_q.clip[19:16]};
			ampf_pkg::REG_CLIP1: st_d.rdata = st_q.clip[15:8];
			ampf_pkg::REG_CLIP0: st_d.rdata = st_q.clip[7:0];
			ampf_pkg::REG_STAT: st_d.rdata = st_q.stat;
			default: st_d.rdata = 8'h00;
		endcase

		// Synchronous reset to constants only
		if (sys_rst) begin
			st_d = '0;
			st_d.pwr = ampf_pkg::PWR_RST;
			st_d.dcb = ampf_pkg::DCB_RST;
			st_d.ramp = ampf_pkg::RAMP_RST;
			st_d.vol = ampf_pkg::VOL_0DB;
			st_d.clip = ampf_pkg::CLIP_RST;
			st_d.vapp = ampf_pkg::VOL_0DB;
			st_d.rbad = 1'b1;
			st_d.flt = ampf_pkg::FLT_RUN;
			st_d.foe_n = 1'b1;
		end
	end

	// State register
	always_ff @(posedge sys_clk) begin
		st_q <= st_d;
	end

	assign reg_rdata = st_q.rdata;
	assign pwm_p = st_q.pp;
	assign pwm_n = st_q.pn;
	assign power_stage_en = st_q.pen;
	assign amp_fault_out_n_o = st_q.fo;
	assign amp_fault_out_n_oe_n = st_q.foe_n;

endmodule : ampf_core

// ---- verif/ampf_core_assertions.sv ----
// Port-level protocol checks of the amplifier core
`timescale 1ns/100ps
module ampf_core_assertions #(
	parameter int unsigned FAULT_TIMEOUT_CYC = 200
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic amp_shutdown_n,
	input wire logic oc_detect,
	input wire logic uv_detect,
	input wire logic ov_detect,
	input wire logic ot_detect,
	input wire logic [1:0] pwm_p,
	input wire logic [1:0] pwm_n,
	input wire logic power_stage_en,
	input wire logic amp_fault_out_n_o,
	input wire logic amp_fault_out_n_oe_n
);
	int unsigned wait_q;
	int unsigned wait_d;

	// Cycles since pin release while the fault line is held
	always_comb begin
		wait_d = wait_q;
		if (amp_fault_out_n_oe_n)
			wait_d = 32'h0;
		else if (wait_q != 32'h0 && wait_q < 32'h0000FFFF)
			wait_d = wait_q + 32'h1;
	end

	// Pin edge restarts the count; sync delay only adds margin
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			wait_q <= 32'h0;
		else if ($rose(amp_shutdown_n))
			wait_q <= 32'h1;
		else
			wait_q <= wait_d;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	property p_pwm_compl;
		power_stage_en && $past(power_stage_en) |-> pwm_n == ~pwm_p;
	endproperty
	a_pwm_compl: assert property (p_pwm_compl)
		else $error("pwm pair not complementary");
	property p_pwm_quiet;
		!power_stage_en && !$past(power_stage_en) |->
			pwm_p == 2'h0 && pwm_n == 2'h0;
	endproperty
	a_pwm_quiet: assert property (p_pwm_quiet)
		else $error("pwm active while stage off");
	property p_od_level;
		amp_fault_out_n_o == 1'b0;
	endproperty
	a_od_level: assert property (p_od_level)
		else $error("fault output drives high");
	property p_oc_latch;
		$rose(oc_detect) && amp_shutdown_n |->
			##[1:10] !amp_fault_out_n_oe_n && !power_stage_en;
	endproperty
	a_oc_latch: assert property (p_oc_latch)
		else $error("overcurrent not faulted");
	property p_ot_latch;
		$rose(ot_detect) && amp_shutdown_n |->
			##[1:10] !amp_fault_out_n_oe_n && !power_stage_en;
	endproperty
	a_ot_latch: assert property (p_ot_latch)
		else $error("overtemp not faulted");
	property p_supply_off;
		$rose(ov_detect || uv_detect) |-> ##[1:10] !power_stage_en;
	endproperty
	a_supply_off: assert property (p_supply_off)
		else $error("stage stays on on supply error");
	property p_supply_nopin;
		$rose(ov_detect || uv_detect) && amp_fault_out_n_oe_n |->
			amp_fault_out_n_oe_n [*8];
	endproperty
	a_supply_nopin: assert property (p_supply_nopin)
		else $error("supply error pulled fault line");
	property p_fault_stage;
		$fell(amp_fault_out_n_oe_n) |-> ##[0:4] !power_stage_en;
	endproperty
	a_fault_stage: assert property (p_fault_stage)
		else $error("stage on while fault pulled");
	property p_sd_off;
		$fell(amp_shutdown_n) |-> ##[1:6] !power_stage_en;
	endproperty
	a_sd_off: assert property (p_sd_off)
		else $error("shutdown pin ignored");
	property p_timeout;
		$rose(amp_fault_out_n_oe_n) && wait_q != 32'h0 |->
			wait_q >= FAULT_TIMEOUT_CYC;
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("fault released before timeout");

	c_latched_release: cover property (
		$rose(amp_fault_out_n_oe_n) && wait_q != 32'h0);
	c_supply: cover property ($rose(ov_detect));
	c_play: cover property ($rose(power_stage_en));
endmodule : ampf_core_assertions

// ---- verif/ampf_i2s_src.sv ----
// Serial audio source model making bit, frame and master clocks
`timescale 1ns/100ps
module ampf_i2s_src #(
	parameter int HALF = 80
) (
	input wire logic run,
	input wire logic [23:0] left,
	input wire logic [23:0] right,
	output logic sclk,
	output logic lrck,
	output logic sdin,
	output logic mclk
);
	logic [23:0] word;

	// Half a bit clock, four master clock edges inside it
	task automatic half_bit();
		repeat (4) begin
			#(HALF / 4);
			mclk = ~mclk;
		end
	endtask : half_bit

	// 64 bit clocks, 256 master clocks a frame
	initial begin
		sclk = 1'b0;
		lrck = 1'b0;
		sdin = 1'b0;
		mclk = 1'b0;
		#1;
		forever begin
			// Clocks stand still while run is low; data keeps moving
			while (!run) begin
				sdin = ~sdin;
				#(HALF);
			end
			for (int ch = 0; ch < 2; ch++) begin
				word = ch[0] ? right : left;
				lrck = ch[0];
				for (int k = 0; k < 32; k++) begin
					sdin = (k >= 1 && k <= 24) ? word[24 - k] : 1'b0;
					half_bit();
					sclk = 1'b1;
					half_bit();
					sclk = 1'b0;
				end
			end
		end
	end
endmodule : ampf_i2s_src

// ---- verif/amp_audio_path_fault_ctrl_tb.sv ----
// Self-checking bench of the amplifier core and audio source
`timescale 1ns/100ps
module amp_audio_path_fault_ctrl_tb;
	localparam int unsigned FT = 200;
	localparam int unsigned STOP = 3000;
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [7:0] exp;
	} ampf_row_t;
	logic sys_clk, sys_rst, sclk, lrck, sdin, mclk, src_run;
	logic sd_n, oc, uv, ov, ot, cool, wr_en;
	logic [7:0] addr, wdata, rdata, v;
	logic [23:0] smp;
	logic [1:0] pwm_p, pwm_n;
	logic stage, flt_o, flt_oe_n, flt_wire;
	int err_total, checked, i;
	int n_hi, n_rise;
	logic sw_mode;
	logic [1:0] rate_pin;
	ampf_row_t rows [8];

	// pull-up holds the line when released
	assign flt_wire = flt_oe_n ? 1'b1 : flt_o;

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	ampf_i2s_src u_src (.run(src_run), .left(smp), .right(smp), .sclk(sclk),
		.lrck(lrck), .sdin(sdin), .mclk(mclk));

	ampf_core #(.DC_CYC(2000), .CLK_STOP_CYC(STOP),
		.FAULT_TIMEOUT_CYC(FT)) DUT (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .aud_sclk(sclk), .aud_lrck(lrck),
		.aud_sdin(sdin), .aud_mclk(mclk), .amp_shutdown_n(sd_n),
		.oc_detect(oc), .uv_detect(uv), .ov_detect(ov), .ot_detect(ot),
		.ot_cool(cool), .sw_ctrl_mode(sw_mode), .pwm_rate_pin(rate_pin),
		.reg_wr_en(wr_en), .reg_addr(addr), .reg_wdata(wdata),
		.reg_rdata(rdata), .pwm_p(pwm_p), .pwm_n(pwm_n),
		.power_stage_en(stage), .amp_fault_out_n_o(flt_o),
		.amp_fault_out_n_oe_n(flt_oe_n));

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		@(negedge sys_clk);
		wr_en = 1'b0;
	endtask : wr

	// Read data is registered: valid one edge after the address
	task automatic rd(input logic [7:0] a);
		@(negedge sys_clk);
		addr = a;
		@(negedge sys_clk);
		v = rdata;
	endtask : rd

	task automatic stat(input int b, input logic e);
		rd(ampf_pkg::REG_STAT);
		check(24'(v[b]), 24'(e));
	endtask : stat

	task automatic toggle_pin();
		@(negedge sys_clk);
		sd_n = 1'b0;
		repeat (10) @(negedge sys_clk);
		sd_n = 1'b1;
	endtask : toggle_pin

	// Bounded wait on the stage (0) or the fault line (1)
	task automatic wait_for(input int n, input int s, input logic lvl);
		for (int k = 0; k < n && ((s == 0 ? stage : flt_wire) !== lvl); k++)
			@(negedge sys_clk);
	endtask : wait_for

	// Left high-side plus right low-side high time and carrier rises of the left pair, 1024 cycles
	task automatic pwm_count(output int hi, output int rises);
		logic last;
		hi = 0;
		rises = 0;
		last = pwm_p[0];
		repeat (1024) begin
			@(negedge sys_clk);
			hi += int'(pwm_p[0]) + int'(pwm_n[1]);
			rises += int'(pwm_p[0] & ~last);
			last = pwm_p[0];
		end
	endtask : pwm_count

	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude

	// Watchdog well beyond the expected run length
	initial begin
		#800_000;
		err_total++;
		conclude();
	end

	initial begin
		{sys_rst, src_run, sd_n, oc, uv, ov, ot, cool} = 8'hA1;
		{wr_en, addr, wdata, smp} = 41'h0;
		{sw_mode, rate_pin} = 3'b100;
		err_total = 0;
		checked = 0;
		rows = '{'{1'b0, ampf_pkg::REG_PWR, 8'h00, ampf_pkg::PWR_RST},
			'{1'b0, ampf_pkg::REG_DCB, 8'h00, ampf_pkg::DCB_RST},
			'{1'b0, ampf_pkg::REG_RAMP, 8'h00, ampf_pkg::RAMP_RST},
			'{1'b0, ampf_pkg::REG_VOL, 8'h00, ampf_pkg::VOL_0DB},
			'{1'b1, ampf_pkg::REG_VOL, 8'hFF, 8'hFF},
			'{1'b1, ampf_pkg::REG_RAMP, 8'h80, 8'h80},
			'{1'b1, 8'h0A, 8'h55, 8'h00},
			'{1'b1, ampf_pkg::REG_VOL, ampf_pkg::VOL_0DB, ampf_pkg::VOL_0DB}};
		repeat (10) @(negedge sys_clk);
		sys_rst = 1'b0;
		// Defaults, write-back and an unmapped place
		foreach (rows[k]) begin
			if (rows[k].wr)
				wr(rows[k].addr, rows[k].wdata);
			rd(rows[k].addr);
			check(24'(v), 24'(rows[k].exp));
		end
		$display("test registers done");
		// No link clocks yet, then a valid source
		check(24'(flt_wire), 24'h0);
		stat(ampf_pkg::ST_CLK, 1'b1);
		src_run = 1'b1;
		wait_for(8000, 0, 1'b1);
		check(24'(flt_wire), 24'h1);
		stat(ampf_pkg::ST_CLK, 1'b0);
		// zero sample gives half duty on both pairs
		pwm_count(n_hi, n_rise);
		check(24'(n_hi), 24'h000400);
		check(24'(n_rise), 24'h000008);
		// pin mode takes the carrier rate from its pins
		{sw_mode, rate_pin} = 3'b001;
		repeat (16) @(negedge sys_clk);
		pwm_count(n_hi, n_rise);
		check(24'(n_rise), 24'h000010);
		{sw_mode, rate_pin} = 3'b100;
		$display("test clock start done");
		// Supply errors stall the drain and overflow the buffer
		for (i = 0; i < 2; i++) begin
			wr(ampf_pkg::REG_STAT, 8'h40);
			{ov, uv} = (i == 1) ? 2'b10 : 2'b01;
			repeat (4600) @(negedge sys_clk);
			check(24'({stage, flt_wire}), 24'h1);
			check(24'({pwm_p, pwm_n}), 24'h0);
			stat(ampf_pkg::ST_UV + i, 1'b1);
			stat(ampf_pkg::ST_OVF, 1'b1);
			{ov, uv} = 2'b00;
			wait_for(50, 0, 1'b1);
			check(24'(stage), 24'h1);
			// Let the full buffer drain before clearing overflow
			repeat (300) @(negedge sys_clk);
			wr(ampf_pkg::REG_STAT, 8'h40);
			stat(ampf_pkg::ST_OVF, 1'b0);
		end
		$display("test supply done");
		// Overcurrent pulse stays latched until toggle and timeout
		oc = 1'b1;
		repeat (10) @(negedge sys_clk);
		oc = 1'b0;
		repeat (500) @(negedge sys_clk);
		check(24'({stage, flt_wire}), 24'h0);
		stat(ampf_pkg::ST_OC, 1'b1);
		toggle_pin();
		repeat (FT - 20) @(negedge sys_clk);
		check(24'(flt_wire), 24'h0);
		wait_for(60, 1, 1'b1);
		check(24'(flt_wire), 24'h1);
		wait_for(5, 0, 1'b1);
		check(24'(stage), 24'h1);
		stat(ampf_pkg::ST_OC, 1'b0);
		$display("test overcurrent done");
		// Error still present at release faults again
		oc = 1'b1;
		repeat (10) @(negedge sys_clk);
		toggle_pin();
		repeat (FT + 50) @(negedge sys_clk);
		check(24'(flt_wire), 24'h0);
		stat(ampf_pkg::ST_OC, 1'b1);
		oc = 1'b0;
		wr(ampf_pkg::REG_PWR, 8'h00);
		wr(ampf_pkg::REG_PWR, ampf_pkg::PWR_RST);
		wait_for(FT + 60, 0, 1'b1);
		check(24'(stage), 24'h1);
		$display("test persisting done");
		// Overtemp needs cooling besides toggle and timeout
		cool = 1'b0;
		ot = 1'b1;
		repeat (10) @(negedge sys_clk);
		ot = 1'b0;
		toggle_pin();
		repeat (FT + 50) @(negedge sys_clk);
		check(24'(flt_wire), 24'h0);
		cool = 1'b1;
		toggle_pin();
		wait_for(FT + 60, 0, 1'b1);
		check(24'({stage, flt_wire}), 24'h3);
		$display("test overtemp done");
		// Stopped clocks fault; return recovers without toggle
		src_run = 1'b0;
		wait_for(STOP + 3000, 1, 1'b0);
		check(24'({stage, flt_wire}), 24'h0);
		src_run = 1'b1;
		wait_for(8000, 0, 1'b1);
		check(24'(flt_wire), 24'h1);
		$display("test clock stop done");
		// bypassed filter lets a constant level reach the outputs
		wr(ampf_pkg::REG_DCB, 8'h81);
		smp = 24'h400000;
		wait_for(20000, 1, 1'b0);
		check(24'({stage, flt_wire}), 24'h0);
		stat(ampf_pkg::ST_DC, 1'b1);
		$display("test dc done");
		conclude();
	end
endmodule : amp_audio_path_fault_ctrl_tb

bind ampf_core ampf_core_assertions #(
	.FAULT_TIMEOUT_CYC(FAULT_TIMEOUT_CYC)
) u_chk (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .amp_shutdown_n(amp_shutdown_n),
	.oc_detect(oc_detect), .uv_detect(uv_detect), .ov_detect(ov_detect),
	.ot_detect(ot_detect), .pwm_p(pwm_p), .pwm_n(pwm_n),
	.power_stage_en(power_stage_en), .amp_fault_out_n_o(amp_fault_out_n_o),
	.amp_fault_out_n_oe_n(amp_fault_out_n_oe_n));
